// >>> hdl/flash_host.sv
// Host-side controller that runs read, reset, identify and program cycles on a flash bus.
`default_nettype none
module flash_host #(
  parameter int BUSY_TIMEOUT_CYC = flash_host_pkg::BUSY_TIMEOUT_DEF
) (
  input wire logic core_clk_in, // 50 MHz clock.
  input wire logic reset_n_in, // Asynchronous reset, active low.
  input wire logic cmd_valid_in, // Command request.
  input wire flash_host_pkg::cmd_s cmd_in, // Operation, address, data.
  output logic cmd_ready_out, // Controller idle, command taken.
  output logic rsp_valid_out, // One-cycle answer pulse.
  output logic [7:0] rsp_data_out, // Byte read or verified.
  output logic rsp_error_out, // Operation failed.
  output logic flash_ce_n_out, // Chip select, active low.
  output logic flash_oe_n_out, // Output enable, active low.
  output logic flash_we_n_out, // Write strobe, active low.
  output logic [19:0] address_lines_out, // Address pins.
  output logic [7:0] data_lines_out, // Data pins, driven value.
  output logic data_lines_oe_out, // High while driving data pins.
  input wire logic [7:0] data_lines_in, // Data pins, sensed value.
  input wire logic ready_busy_od_in, // Pulled-up ready/busy pin.
  output logic high_voltage_id_level_out, // Apply identify voltage to A9.
  output logic hard_reset_unlock_n_out // Device hard reset, active low.
);
  typedef struct packed {
    flash_host_pkg::state_e st;
    flash_host_pkg::cmd_s cmd;
    logic [2:0] step;
    logic rd;
    logic pre;
    logic err;
    logic [flash_host_pkg::CNT_W-1:0] cnt;
    flash_host_pkg::pins_s pins;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_error;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '{st: flash_host_pkg::S_IDLE,
                                 cmd: '{op: flash_host_pkg::OP_READ, addr: 20'h00000,
                                        data: 8'h00},
                                 step: 3'h0, rd: 1'b0, pre: 1'b0, err: 1'b0,
                                 cnt: '0, pins: flash_host_pkg::PINS_IDLE,
                                 rsp_valid: 1'b0, rsp_data: 8'h00, rsp_error: 1'b0};
  localparam logic [flash_host_pkg::CNT_W-1:0] WE_LOW_C =
    flash_host_pkg::CNT_W'(flash_host_pkg::WE_LOW_CYC);
  localparam logic [flash_host_pkg::CNT_W-1:0] RECOVER_C =
    flash_host_pkg::CNT_W'(flash_host_pkg::RECOVER_CYC);
  localparam logic [flash_host_pkg::CNT_W-1:0] READ_C =
    flash_host_pkg::CNT_W'(flash_host_pkg::READ_CYC);
  localparam logic [flash_host_pkg::CNT_W-1:0] ABORT_C =
    flash_host_pkg::CNT_W'(flash_host_pkg::ABORT_CYC);
  localparam logic [flash_host_pkg::CNT_W-1:0] SETTLE_C =
    flash_host_pkg::CNT_W'(flash_host_pkg::BUSY_SETTLE_CYC);
  localparam logic [flash_host_pkg::CNT_W-1:0] TIMEOUT_C =
    flash_host_pkg::CNT_W'(BUSY_TIMEOUT_CYC);

  logic [1:0] rst_q_r;
  logic rst_n;
  logic [8:0] sync_pins;
  logic [7:0] rdata;
  logic rb_ready;
  ctrl_s c_r;
  ctrl_s c_nxt;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_q_r <= 2'h0;
    end else begin
      rst_q_r <= {rst_q_r[0], 1'b1};
    end
  end
  assign rst_n = rst_q_r[1];

  pin_sync #(.WIDTH(9)) u_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .async_in({ready_busy_od_in, data_lines_in}),
    .sync_out(sync_pins)
  );
  assign rdata = sync_pins[7:0];
  assign rb_ready = sync_pins[8];

  // Number of bus writes each command needs.
  function automatic logic [2:0] n_writes(input flash_host_pkg::op_e op);
    case (op)
      flash_host_pkg::OP_RESET_SHORT: n_writes = 3'h1;
      flash_host_pkg::OP_RESET_LONG: n_writes = 3'h3;
      flash_host_pkg::OP_AUTOSEL: n_writes = 3'h3;
      flash_host_pkg::OP_PROGRAM: n_writes = 3'h4;
      default: n_writes = 3'h0;
    endcase
  endfunction

  // Address and data of write number step; unlock writes leave the upper address bits zero.
  function automatic logic [27:0] wr_word(input flash_host_pkg::cmd_s cmd,
                                          input logic [2:0] step);
    logic [7:0] cbyte;
    cbyte = flash_host_pkg::CMD_PROGRAM;
    if (cmd.op == flash_host_pkg::OP_RESET_LONG) begin
      cbyte = flash_host_pkg::CMD_RESET;
    end else if (cmd.op == flash_host_pkg::OP_AUTOSEL) begin
      cbyte = flash_host_pkg::CMD_AUTOSEL;
    end
    case (step)
      3'h0: begin
        if (cmd.op == flash_host_pkg::OP_RESET_SHORT) begin
          wr_word = {cmd.addr, flash_host_pkg::CMD_RESET};
        end else begin
          wr_word = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::UNLOCK1_DATA};
        end
      end
      3'h1: wr_word = {flash_host_pkg::UNLOCK2_ADDR, flash_host_pkg::UNLOCK2_DATA};
      3'h2: wr_word = {flash_host_pkg::UNLOCK1_ADDR, cbyte};
      default: wr_word = {cmd.addr, cmd.data};
    endcase
  endfunction

  always_comb begin
    c_nxt = c_r;
    c_nxt.rsp_valid = 1'b0;
    c_nxt.pins.hard_rst_n = 1'b1;
    case (c_r.st)
      flash_host_pkg::S_IDLE: begin
        if (cmd_valid_in) begin
          c_nxt.cmd = cmd_in;
          c_nxt.step = 3'h0;
          c_nxt.err = 1'b0;
          c_nxt.pre = (cmd_in.op == flash_host_pkg::OP_PROGRAM);
          c_nxt.rd = (cmd_in.op == flash_host_pkg::OP_READ) ||
                     (cmd_in.op == flash_host_pkg::OP_PIN_ID) ||
                     (cmd_in.op == flash_host_pkg::OP_PROGRAM);
          c_nxt.pins.high_voltage_id_level = (cmd_in.op == flash_host_pkg::OP_PIN_ID);
          c_nxt.st = flash_host_pkg::S_SETUP;
        end
      end
      flash_host_pkg::S_SETUP: begin
        // Address settles with the write strobe high, so it is stable before it falls; for reads output enable falls here too.
        c_nxt.cnt = '0;
        c_nxt.pins.ce_n = 1'b0;
        c_nxt.pins.we_n = 1'b1;
        if (c_r.rd) begin
          c_nxt.pins.addr = c_r.cmd.addr;
          c_nxt.pins.dout_oe = 1'b0;
          c_nxt.pins.oe_n = 1'b0;
        end else begin
          {c_nxt.pins.addr, c_nxt.pins.dout} = wr_word(c_r.cmd, c_r.step);
          c_nxt.pins.dout_oe = 1'b1;
          c_nxt.pins.oe_n = 1'b1;
        end
        c_nxt.st = flash_host_pkg::S_STROBE;
      end
      flash_host_pkg::S_STROBE: begin
        c_nxt.pins.we_n = c_r.rd;
        c_nxt.cnt = c_r.cnt + 1'b1;
        if (c_r.cnt == (c_r.rd ? READ_C : WE_LOW_C)) begin
          // Strobes rise together while data is still driven.
          c_nxt.pins.ce_n = 1'b1;
          c_nxt.pins.we_n = 1'b1;
          c_nxt.pins.oe_n = 1'b1;
          c_nxt.cnt = '0;
          if (c_r.rd) begin
            c_nxt.rsp_data = rdata;
          end
          c_nxt.st = flash_host_pkg::S_RECOVER;
        end
      end
      flash_host_pkg::S_RECOVER: begin
        c_nxt.pins.dout_oe = 1'b0;
        c_nxt.cnt = c_r.cnt + 1'b1;
        if (c_r.cnt == RECOVER_C) begin
          c_nxt.cnt = '0;
          c_nxt.st = flash_host_pkg::S_RESP;
          if (c_r.rd && c_r.cmd.op == flash_host_pkg::OP_PROGRAM) begin
            if (c_r.pre) begin
              c_nxt.pre = 1'b0;
              if ((c_r.rsp_data & c_r.cmd.data) != c_r.cmd.data) begin
                c_nxt.err = 1'b1;
              end else begin
                c_nxt.rd = 1'b0;
                c_nxt.st = flash_host_pkg::S_SETUP;
              end
            end else if (c_r.rsp_data != c_r.cmd.data) begin
              // Covers a protected target too: it is discarded and never busy.
              c_nxt.err = 1'b1;
              c_nxt.cmd.op = flash_host_pkg::OP_RESET_SHORT;
              c_nxt.step = 3'h0;
              c_nxt.rd = 1'b0;
              c_nxt.st = flash_host_pkg::S_SETUP;
            end
          end else if (!c_r.rd) begin
            c_nxt.step = c_r.step + 3'h1;
            if (c_r.step + 3'h1 < n_writes(c_r.cmd.op)) begin
              c_nxt.st = flash_host_pkg::S_SETUP;
            end else if (c_r.cmd.op == flash_host_pkg::OP_PROGRAM) begin
              c_nxt.st = flash_host_pkg::S_BUSY;
            end else if (c_r.cmd.op != flash_host_pkg::OP_AUTOSEL) begin
              c_nxt.st = flash_host_pkg::S_ABORT;
            end
          end
        end
      end
      flash_host_pkg::S_BUSY: begin
        // No command or read is issued here; any read would only return status.
        c_nxt.cnt = c_r.cnt + 1'b1;
        if (c_r.cnt >= SETTLE_C && rb_ready) begin
          c_nxt.cnt = '0;
          c_nxt.rd = 1'b1;
          c_nxt.st = flash_host_pkg::S_SETUP;
        end else if (c_r.cnt == TIMEOUT_C) begin
          c_nxt.err = 1'b1;
          c_nxt.cmd.op = flash_host_pkg::OP_RESET_SHORT;
          c_nxt.step = 3'h0;
          c_nxt.rd = 1'b0;
          c_nxt.st = flash_host_pkg::S_SETUP;
        end
      end
      flash_host_pkg::S_ABORT: begin
        // A reset may abort an erase or clear an error; the device is unreadable meanwhile.
        c_nxt.cnt = c_r.cnt + 1'b1;
        if (c_r.cnt == ABORT_C) begin
          c_nxt.st = flash_host_pkg::S_RESP;
        end
      end
      flash_host_pkg::S_RESP: begin
        c_nxt.rsp_valid = 1'b1;
        c_nxt.rsp_error = c_r.err;
        c_nxt.pins.high_voltage_id_level = 1'b0;
        c_nxt.st = flash_host_pkg::S_IDLE;
      end
      default: c_nxt.st = flash_host_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      c_r <= CTRL_RST;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign cmd_ready_out = (c_r.st == flash_host_pkg::S_IDLE);
  assign rsp_valid_out = c_r.rsp_valid;
  assign rsp_data_out = c_r.rsp_data;
  assign rsp_error_out = c_r.rsp_error;
  assign flash_ce_n_out = c_r.pins.ce_n;
  assign flash_oe_n_out = c_r.pins.oe_n;
  assign flash_we_n_out = c_r.pins.we_n;
  assign address_lines_out = c_r.pins.addr;
  assign data_lines_out = c_r.pins.dout;
  assign data_lines_oe_out = c_r.pins.dout_oe;
  assign high_voltage_id_level_out = c_r.pins.high_voltage_id_level;
  assign hard_reset_unlock_n_out = c_r.pins.hard_rst_n;
endmodule
`default_nettype wire

// >>> hdl/flash_host_pkg.sv
// Shared types and constants for the parallel flash host controller.
`default_nettype none
package flash_host_pkg;
  localparam int CLK_NS = 20;
  // Strobe low time; well above the 5 ns the device treats as a glitch.
  localparam int WE_LOW_NS = 40;
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  // Gap with select high after each cycle, also covers the 50 ns re-read wait.
  localparam int RECOVER_NS = 50;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  // Read access time plus the two synchroniser stages on the data inputs.
  localparam int ACCESS_NS = 70;
  localparam int SYNC_STAGES = 2;
  localparam int READ_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  localparam int ABORT_US = 10;
  localparam int ABORT_CYC = (ABORT_US * 1000) / CLK_NS;
  // Cycles after the last program write before the busy pin is trusted.
  localparam int BUSY_SETTLE_CYC = 4;
  localparam int BUSY_TIMEOUT_DEF = 65536;
  localparam int CNT_W = 24;

  localparam logic [19:0] UNLOCK1_ADDR = 20'h00555;
  localparam logic [19:0] UNLOCK2_ADDR = 20'h002aa;
  localparam logic [7:0] UNLOCK1_DATA = 8'haa;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_RESET_SHORT = 3'h1,
    OP_RESET_LONG = 3'h2,
    OP_AUTOSEL = 3'h3,
    OP_PROGRAM = 3'h4,
    OP_PIN_ID = 3'h5
  } op_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SETUP = 3'h1,
    S_STROBE = 3'h2,
    S_RECOVER = 3'h3,
    S_BUSY = 3'h4,
    S_ABORT = 3'h5,
    S_RESP = 3'h6
  } state_e;

  typedef struct packed {
    op_e op;
    logic [19:0] addr;
    logic [7:0] data;
  } cmd_s;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [19:0] addr;
    logic [7:0] dout;
    logic dout_oe;
    logic high_voltage_id_level;
    logic hard_rst_n;
  } pins_s;

  localparam pins_s PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 20'h00000,
                                  dout: 8'h00, dout_oe: 1'b0, high_voltage_id_level: 1'b0, hard_rst_n: 1'b0};
endpackage
`default_nettype wire

// >>> hdl/pin_sync.sv
// Two-flop synchroniser for inputs arriving from the flash pins.
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 9
) (
  input wire logic core_clk_in, // Core clock.
  input wire logic rst_n_in, // Synchronised reset, active low.
  input wire logic [WIDTH-1:0] async_in, // Pin levels.
  output logic [WIDTH-1:0] sync_out // Levels after two flops.
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> verif/flash_host_properties.sv
// Pin-level protocol checker for the flash host controller.
`default_nettype none
module flash_host_properties (
  input wire logic core_clk_in, // Clock.
  input wire logic reset_n_in, // Reset, active low.
  input wire logic flash_ce_n_out, // Chip select.
  input wire logic flash_oe_n_out, // Output enable.
  input wire logic flash_we_n_out, // Write strobe.
  input wire logic [19:0] address_lines_out, // Address pins.
  input wire logic [7:0] data_lines_out, // Write data.
  input wire logic data_lines_oe_out, // Host drives data.
  input wire logic ready_busy_od_in // Ready/busy pin.
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  sequence s_we_low;
    !flash_we_n_out [*2];
  endsequence
  sequence s_ce_idle;
    flash_ce_n_out [*4];
  endsequence
  AST_OE_WRITE: assert property (!flash_we_n_out |-> flash_oe_n_out)
    else $error("output enable low during a write");
  AST_READ_QUIET: assert property (!flash_oe_n_out |->
    flash_we_n_out && !flash_ce_n_out && !data_lines_oe_out)
    else $error("read without select or with host driving");
  AST_ADDR_SETUP: assert property ($fell(flash_we_n_out) |->
    $stable(address_lines_out) && !$past(flash_ce_n_out))
    else $error("address not set before strobe fell");
  AST_DATA_HOLD: assert property ($rose(flash_we_n_out) |->
    data_lines_oe_out && $past(data_lines_oe_out) && $stable(data_lines_out))
    else $error("write data not held through strobe rise");
  AST_WE_WIDTH: assert property ($fell(flash_we_n_out) |-> s_we_low)
    else $error("write strobe too short");
  AST_CE_RECOVER: assert property ($rose(flash_ce_n_out) |-> s_ce_idle)
    else $error("select gap too short");
  AST_READ_ADDR: assert property (!flash_oe_n_out && $past(!flash_oe_n_out) |->
    $stable(address_lines_out))
    else $error("address moved during a read");
  AST_BUSY_NO_WRITE: assert property (!ready_busy_od_in |-> flash_we_n_out)
    else $error("write issued while device busy");
endmodule
bind flash_host flash_host_properties u_props (.core_clk_in, .reset_n_in, .flash_ce_n_out,
  .flash_oe_n_out, .flash_we_n_out, .address_lines_out, .data_lines_out,
  .data_lines_oe_out, .ready_busy_od_in);
`default_nettype wire

// >>> verif/flash_dev_model.sv
// Behavioural model of the byte-wide flash device driven by the host.
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value.
  parameter logic [7:0] PART_CODE = 8'hc3, // Arbitrary value.
  parameter logic [15:0] PROT_MAP = 16'h0008,
  parameter int PROG_NS = 400
) (
  input wire logic ce_n_in, // Chip select.
  input wire logic oe_n_in, // Output enable.
  input wire logic we_n_in, // Write strobe.
  input wire logic [19:0] addr_in, // Address pins.
  input wire logic [7:0] data_in, // Host write data.
  input wire logic vid_in, // Identify voltage on A9.
  input wire logic fail_in, // Make programming fail.
  output logic [7:0] data_out, // Data pins as seen by the host.
  output logic rb_out // Ready/busy after pull-up.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [int];
  logic [7:0] q, pd = 8'h00, last = 8'h00;
  logic [19:0] la;
  logic [1:0] step = 2'h0;
  logic idm = 1'b0, busy = 1'b0, err = 1'b0;
  time tf = 0, abort_t = 0;
  wire wr_n = ce_n_in | we_n_in;
  assign rb_out = !busy;
  always @(negedge wr_n) begin
    la = addr_in;
    tf = $time;
  end
  task automatic prog(input logic [19:0] a, input logic [7:0] d);
    busy = 1'b1;
    pd = d;
    fork begin
      #(PROG_NS);
      if (fail_in) err = 1'b1;
      else mem[a] = (mem.exists(a) ? mem[a] : 8'hff) & d;
      busy = 1'b0;
    end join_none
  endtask
  always @(posedge wr_n) begin
    if (oe_n_in && !busy && $time - tf >= 5) begin
      if (data_in == 8'hf0 && step != 2'h1 && step != 2'h3) begin
        if (err) abort_t = $time + 10000;
        step = 2'h0;
        idm = 1'b0;
        err = 1'b0;
      end else if (step == 2'h3) begin
        step = 2'h0;
        if (!PROT_MAP[la[19:16]]) prog(la, data_in);
      end else if (la[10:0] == 11'h555 && data_in == 8'haa && step == 2'h0) begin
        step = 2'h1;
      end else if (la[10:0] == 11'h2aa && data_in == 8'h55 && step == 2'h1) begin
        step = 2'h2;
      end else if (la[10:0] == 11'h555 && data_in == 8'h90 && step == 2'h2) begin
        step = 2'h0;
        idm = 1'b1;
      end else if (la[10:0] == 11'h555 && data_in == 8'ha0 && step == 2'h2) begin
        step = 2'h3;
      end else begin
        step = 2'h0;
        idm = 1'b0;
      end
    end
  end
  // Polled rather than event driven so that the abort window expires on its own.
  always begin
    #5;
    q = mem.exists(addr_in) ? mem[addr_in] : 8'hff;
    if (busy || err) q = ~pd;
    else if ($time < abort_t) q = 8'h5a;
    else if (idm || vid_in) begin
      case (addr_in[1:0])
        2'h0: q = MAKER_CODE;
        2'h1: q = PART_CODE;
        2'h2: if (idm) q = {7'h00, PROT_MAP[addr_in[19:16]]};
        default: ;
      endcase
    end
    if (!ce_n_in && !oe_n_in) last = q;
    data_out = (!ce_n_in && !oe_n_in) ? q : ~last;
  end
endmodule
`default_nettype wire

// >>> verif/tb_flash_host.sv
// Self-checking testbench for the flash host controller.
`default_nettype none
module tb_flash_host;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MAKER = 8'h3c;
  localparam logic [7:0] PART = 8'hc3;
  logic core_clk_in = 1'b0, reset_n_in = 1'b0, cmd_valid = 1'b0, fail = 1'b0;
  flash_host_pkg::cmd_s cmd = '0;
  logic ce_n, oe_n, we_n, doe, high_voltage_id_level, rdy, rv, re, rb, hrst_n;
  logic [19:0] addr;
  logic [7:0] dout, din, rd;
  int error_cnt = 0, comparisons = 0, cycles = 0;
  always #10 core_clk_in = ~core_clk_in;
  flash_host #(.BUSY_TIMEOUT_CYC(64)) u_dut (.core_clk_in, .reset_n_in,
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .cmd_ready_out(rdy), .rsp_valid_out(rv),
    .rsp_data_out(rd), .rsp_error_out(re), .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n),
    .flash_we_n_out(we_n), .address_lines_out(addr), .data_lines_out(dout),
    .data_lines_oe_out(doe), .data_lines_in(din), .ready_busy_od_in(rb),
    .high_voltage_id_level_out(high_voltage_id_level), .hard_reset_unlock_n_out(hrst_n));
  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_dev (.ce_n_in(ce_n),
    .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(addr), .data_in(dout), .vid_in(high_voltage_id_level),
    .fail_in(fail), .data_out(din), .rb_out(rb));
  task automatic complete_run;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input flash_host_pkg::op_e op, input logic [19:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 3000) begin
      @(negedge core_clk_in);
      n++;
    end
    @(posedge core_clk_in);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, addr: a, data: d};
    @(posedge core_clk_in);
    cmd_valid <= 1'b0;
    do begin
      @(negedge core_clk_in);
      n++;
    end while (rv !== 1'b1 && n < 3000);
    // A command that never answers must not let a stale response pass the checks.
    if (rv !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t no response to command", $time);
    end
  endtask
  task automatic read_chk(input logic [19:0] a, input logic [7:0] exp);
    run(flash_host_pkg::OP_READ, a, 8'h00);
    chk8(rd, exp);
  endtask
  task automatic t_program(input logic [19:0] a, input logic [7:0] d, input logic e,
                           input logic [7:0] after);
    run(flash_host_pkg::OP_PROGRAM, a, d);
    chk8({7'h00, re}, {7'h00, e});
    read_chk(a, after);
  endtask
  task automatic t_autosel(input flash_host_pkg::op_e rst_op);
    run(flash_host_pkg::OP_AUTOSEL, 20'h00000, 8'h90);
    chk8({7'h00, re}, 8'h00);
    read_chk(20'h00000, MAKER);
    read_chk(20'hfff01, PART);
    read_chk(20'h30002, 8'h01);
    read_chk(20'h4fffe, 8'h00);
    run(rst_op, 20'h00000, 8'hf0);
    read_chk(20'h12345, 8'ha5);
  endtask
  task automatic t_pin_id;
    run(flash_host_pkg::OP_PIN_ID, 20'h00000, 8'h00);
    chk8(rd, MAKER);
    run(flash_host_pkg::OP_PIN_ID, 20'h00001, 8'h00);
    chk8(rd, PART);
  endtask
  initial begin
    repeat (6) @(posedge core_clk_in);
    chk8({7'h00, hrst_n}, 8'h00);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    // The hard reset pin is launched on the third edge, so look half a cycle later.
    @(negedge core_clk_in);
    chk8({7'h00, hrst_n}, 8'h01);
    read_chk(20'h12345, 8'hff);
    t_program(20'h12345, 8'ha5, 1'b0, 8'ha5);
    t_program(20'h12345, 8'hff, 1'b1, 8'ha5);
    t_program(20'h3ffff, 8'h00, 1'b1, 8'hff);
    @(posedge core_clk_in);
    fail <= 1'b1;
    t_program(20'h00010, 8'h0f, 1'b1, 8'hff);
    @(posedge core_clk_in);
    fail <= 1'b0;
    t_autosel(flash_host_pkg::OP_RESET_SHORT);
    t_autosel(flash_host_pkg::OP_RESET_LONG);
    t_pin_id();
    complete_run();
  end
endmodule
`default_nettype wire
